//--- src/rldac_top.sv
`timescale 1ns/100ps
`default_nettype none
// Function
// - Pin output enable routes the ladder level to the reference output pin.
// - While pin carries the level, digital driver and input detection are off.
// - Port read of the reference output pin returns zero while analog.
// - Low-power select keeps positive end when set, negative end when clear.
// - Control register is untouched by a wake from sleep.
// - Reset disables ladder, releases pin, clears code and all fields.
// - Bit 7 of control turns the ladder on.
// - Five-bit code in level register picks one of 32 fractions.
// - Positive select: 00 supply, 01 external, 10 fixed reference, 11 reserved.
// - Bit 0 of control picks external negative reference or ground.
// - Unimplemented bits read zero and ignore writes.
// - Level code sits right-justified in its register.
module rldac_top
  import rldac_pkg::*;
(
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  input  wire logic [RLDAC_AW-1:0] i_addr,
  input  wire logic [RLDAC_DW-1:0] i_wdata,
  input  wire logic                i_wr,
  input  wire logic                i_rd,
  output logic      [RLDAC_DW-1:0] o_rdata,
  input  wire logic                i_sleep_wake,
  input  wire logic                i_pin_level,
  output logic                     o_port_read_bit,
  output var rldac_ladder_s        o_ladder,
  output var rldac_pin_s           o_pin,
  output var rldac_fields_s        o_fields
);

  typedef struct packed
  {
    logic [RLDAC_DW-1:0] control;
    logic [RLDAC_DW-1:0] level;
    logic [RLDAC_DW-1:0] rdata;
  } rldac_state_s;

  rldac_state_s state_q;
  rldac_state_s state_d;

  always_comb
  begin
    state_d = state_q;
    state_d.rdata = '0;
    if (i_wr)
    begin
      if (i_addr == RLDAC_ADDR_CONTROL)
      begin
        state_d.control = i_wdata & RLDAC_CONTROL_MASK;
      end
      else if (i_addr == RLDAC_ADDR_LEVEL)
      begin
        state_d.level = i_wdata & RLDAC_LEVEL_MASK;
      end
    end
    if (i_rd)
    begin
      if (i_addr == RLDAC_ADDR_CONTROL)
      begin
        state_d.rdata = state_q.control;
      end
      else if (i_addr == RLDAC_ADDR_LEVEL)
      begin
        state_d.rdata = state_q.level;
      end
    end
    // Wake from sleep has no path here, so control keeps its value
    if (i_rst)
    begin
      state_d.control = RLDAC_CONTROL_RESET;
      state_d.level = RLDAC_LEVEL_RESET;
      state_d.rdata = '0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    state_q <= state_d;
  end

  assign o_rdata = state_q.rdata;

  always_comb
  begin
    o_fields.ladder_enable = state_q.control[RLDAC_BIT_EN];
    o_fields.low_power_end_select = state_q.control[RLDAC_BIT_LPS];
    o_fields.ladder_pin_output_enable = state_q.control[RLDAC_BIT_OE];
    o_fields.positive_source_select = rldac_pss_e'(state_q.control[RLDAC_BIT_PSS0 +: 2]);
    o_fields.negative_source_select = state_q.control[RLDAC_BIT_NSS];
    o_fields.level_code = state_q.level[RLDAC_BIT_CODE0 +: RLDAC_CODE_W];
  end

  rldac_source_decode u_decode
  (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .i_fields (o_fields),
    .o_ladder (o_ladder)
  );

  rldac_pin_override u_pin
  (
    .i_clk           (i_clk),
    .i_rst           (i_rst),
    .i_output_enable (o_fields.ladder_pin_output_enable),
    .i_pin_level     (i_pin_level),
    .o_pin           (o_pin),
    .o_port_read_bit (o_port_read_bit)
  );

  sequence ctl_write_s;
    i_wr && (i_addr == RLDAC_ADDR_CONTROL);
  endsequence

  sequence lvl_write_s;
    i_wr && (i_addr == RLDAC_ADDR_LEVEL);
  endsequence

  ctl_update_a: assert property (@(posedge i_clk) disable iff (i_rst)
    ctl_write_s |=> state_q.control == ($past(i_wdata) & RLDAC_CONTROL_MASK))
    else $error("control write not stored");

  lvl_code_a: assert property (@(posedge i_clk) disable iff (i_rst)
    lvl_write_s |=> o_fields.level_code == $past(i_wdata[RLDAC_BIT_CODE0 +: RLDAC_CODE_W]))
    else $error("level code not stored");

  unimpl_zero_a: assert property (@(posedge i_clk) disable iff (i_rst)
    ((state_q.control & ~RLDAC_CONTROL_MASK) == '0) && ((state_q.level & ~RLDAC_LEVEL_MASK) == '0))
    else $error("unimplemented bit set");

  read_data_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_rd && i_addr == RLDAC_ADDR_LEVEL) |=> o_rdata == $past(state_q.level))
    else $error("level read wrong");

  reset_clear_a: assert property (@(posedge i_clk)
    i_rst |=> (state_q.control == '0) && (state_q.level == '0))
    else $error("reset did not clear");

  pin_route_a: assert property (@(posedge i_clk) disable iff (i_rst)
    ctl_write_s ##1 1'b1 ##1 1'b1 |-> o_pin.analog_connect == $past(i_wdata[RLDAC_BIT_OE], 2))
    else $error("pin route mismatch");

  drive_off_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_pin.analog_connect |-> o_pin.digital_drive_off && o_pin.input_detect_off)
    else $error("digital not disabled");

  wake_keep_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_sleep_wake && !(i_wr && (i_addr == RLDAC_ADDR_CONTROL))) |=> $stable(state_q.control))
    else $error("wake changed control");

  // Read data stands for one cycle only, so a stale value never looks like a fresh read
  rdata_idle_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_rd |=> o_rdata == '0)
    else $error("read data not idle");

  neg_select_a: assert property (@(posedge i_clk) disable iff (i_rst)
    ctl_write_s ##2 1'b1 |-> o_ladder.sel_ext_neg_ref == $past(i_wdata[RLDAC_BIT_NSS], 2))
    else $error("negative source mismatch");

  reset_fields_a: assert property (@(posedge i_clk)
    i_rst |=> !o_fields.ladder_enable && !o_fields.ladder_pin_output_enable && (o_fields.level_code == '0))
    else $error("reset left fields set");

  enable_a: assert property (@(posedge i_clk) disable iff (i_rst)
    ctl_write_s ##2 1'b1 |-> o_ladder.ladder_on == $past(i_wdata[RLDAC_BIT_EN], 2))
    else $error("ladder enable mismatch");

endmodule
`default_nettype wire

//--- src/rldac_pkg.sv
package rldac_pkg;

  localparam int unsigned RLDAC_AW = 1;
  localparam int unsigned RLDAC_DW = 8;
  localparam int unsigned RLDAC_CODE_W = 5;

  localparam logic [RLDAC_AW-1:0] RLDAC_ADDR_CONTROL = 1'h0;
  localparam logic [RLDAC_AW-1:0] RLDAC_ADDR_LEVEL   = 1'h1;

  localparam int unsigned RLDAC_BIT_EN   = 7;
  localparam int unsigned RLDAC_BIT_LPS  = 6;
  localparam int unsigned RLDAC_BIT_OE   = 5;
  localparam int unsigned RLDAC_BIT_PSS0 = 2;
  localparam int unsigned RLDAC_BIT_NSS  = 0;
  localparam int unsigned RLDAC_BIT_CODE0 = 0;

  localparam logic [7:0] RLDAC_CONTROL_RESET = 8'h00;
  localparam logic [7:0] RLDAC_LEVEL_RESET   = 8'h00;
  localparam logic [7:0] RLDAC_CONTROL_MASK  = 8'hed;
  localparam logic [7:0] RLDAC_LEVEL_MASK    = 8'h1f;

  typedef enum logic [1:0]
  {
    RLDAC_PSS_SUPPLY   = 2'h0,
    RLDAC_PSS_EXT_REF  = 2'h1,
    RLDAC_PSS_FIXED    = 2'h2,
    RLDAC_PSS_RESERVED = 2'h3
  } rldac_pss_e;

  typedef struct packed
  {
    logic       ladder_enable;
    logic       low_power_end_select;
    logic       ladder_pin_output_enable;
    rldac_pss_e positive_source_select;
    logic       negative_source_select;
    logic [4:0] level_code;
  } rldac_fields_s;

  typedef struct packed
  {
    logic                 sel_supply;
    logic                 sel_ext_pos_ref;
    logic                 sel_fixed_reference;
    logic                 sel_ext_neg_ref;
    logic                 sel_ground;
    logic                 pos_end_connected;
    logic                 neg_end_connected;
    logic                 ladder_on;
    logic [4:0]           level_code;
  } rldac_ladder_s;

  typedef struct packed
  {
    logic analog_connect;
    logic digital_drive_off;
    logic input_detect_off;
  } rldac_pin_s;

endpackage

//--- src/rldac_source_decode.sv
`timescale 1ns/100ps
`default_nettype none
module rldac_source_decode
  import rldac_pkg::*;
(
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  input  wire rldac_fields_s i_fields,
  output var  rldac_ladder_s o_ladder
);

  typedef struct packed
  {
    rldac_ladder_s ladder;
  } rldac_dec_state_s;

  rldac_dec_state_s state_q;
  rldac_dec_state_s state_d;

  always_comb
  begin
    state_d = state_q;
    state_d.ladder.ladder_on = i_fields.ladder_enable;
    state_d.ladder.sel_supply = (i_fields.positive_source_select == RLDAC_PSS_SUPPLY);
    state_d.ladder.sel_ext_pos_ref = (i_fields.positive_source_select == RLDAC_PSS_EXT_REF);
    // Reserved code selects no source so nothing shorts
    state_d.ladder.sel_fixed_reference = (i_fields.positive_source_select == RLDAC_PSS_FIXED);
    state_d.ladder.sel_ext_neg_ref = i_fields.negative_source_select;
    state_d.ladder.sel_ground = ~i_fields.negative_source_select;
    // While enabled both ends stay on; when off only the chosen end remains
    state_d.ladder.pos_end_connected = i_fields.ladder_enable | i_fields.low_power_end_select;
    state_d.ladder.neg_end_connected = i_fields.ladder_enable | ~i_fields.low_power_end_select;
    state_d.ladder.level_code = i_fields.level_code;
    if (i_rst)
    begin
      state_d = '0;
      state_d.ladder.sel_supply = 1'b1;
      state_d.ladder.sel_ground = 1'b1;
      state_d.ladder.neg_end_connected = 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    state_q <= state_d;
  end

  assign o_ladder = state_q.ladder;

  pss_onehot_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $onehot0({o_ladder.sel_supply, o_ladder.sel_ext_pos_ref, o_ladder.sel_fixed_reference}))
    else $error("positive source selects overlap");

  lps_end_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_fields.ladder_enable |=> (o_ladder.pos_end_connected == $past(i_fields.low_power_end_select))
      && (o_ladder.neg_end_connected != $past(i_fields.low_power_end_select)))
    else $error("low power end wrong");

endmodule
`default_nettype wire

//--- src/rldac_pin_override.sv
`timescale 1ns/100ps
`default_nettype none
module rldac_pin_override
  import rldac_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_output_enable,
  input  wire logic       i_pin_level,
  output var  rldac_pin_s o_pin,
  output logic            o_port_read_bit
);

  typedef struct packed
  {
    logic       connect;
    logic [1:0] sync;
  } rldac_pin_state_s;

  rldac_pin_state_s state_q;
  rldac_pin_state_s state_d;

  always_comb
  begin
    state_d = state_q;
    state_d.connect = i_output_enable;
    state_d.sync = {state_q.sync[0], i_pin_level};
    if (i_rst)
    begin
      state_d = '0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    state_q <= state_d;
  end

  assign o_pin.analog_connect = state_q.connect;
  assign o_pin.digital_drive_off = state_q.connect;
  assign o_pin.input_detect_off = state_q.connect;
  // Gate on the registered connect so the read agrees with the pin state
  assign o_port_read_bit = state_q.sync[1] & ~state_q.connect;

  read_zero_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_pin.analog_connect |-> !o_port_read_bit)
    else $error("pin read not zero while analog");

endmodule
`default_nettype wire

//--- tb/rldac_ladder_model.sv
`timescale 1ns/100ps
`default_nettype none
module rldac_ladder_model
  import rldac_pkg::*;
(
  input  wire logic          i_ext_level,
  input  wire rldac_ladder_s i_ladder,
  input  wire rldac_pin_s    i_pin,
  output logic [5:0]         o_vout,
  output logic               o_pin_level
);
  // Output in 32nds of the span; 3f marks a state with no defined level
  always_comb
  begin
    if (i_ladder.ladder_on)
      o_vout = {1'b0, i_ladder.level_code};
    else if (i_ladder.pos_end_connected && !i_ladder.neg_end_connected)
      o_vout = (i_ladder.level_code == 5'h1f) ? 6'h20 : 6'h3f;
    else if (i_ladder.neg_end_connected && !i_ladder.pos_end_connected)
      o_vout = (i_ladder.level_code == 5'h00) ? 6'h00 : 6'h3f;
    else
      o_vout = 6'h3f;
  end
  // A high analog level makes a missing read override visible
  assign o_pin_level = i_pin.analog_connect ? (o_vout[4] | o_vout[5]) : i_ext_level;
endmodule
`default_nettype wire

//--- tb/test_ref_ladder_dac_control.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    checks++; \
    if ((got) !== (ex)) \
    begin \
      errors++; \
      $display("unexpected %s exp %h got %h", nm, ex, got); \
    end \
  end
module test_ref_ladder_dac_control
  import rldac_pkg::*;
;
  logic                i_clk;
  logic                i_rst;
  logic [RLDAC_AW-1:0] i_addr;
  logic [7:0]          i_wdata;
  logic                i_wr;
  logic                i_rd;
  logic [7:0]          o_rdata;
  logic                i_sleep_wake;
  logic                pin_level;
  logic                ext_level;
  logic                port_bit;
  logic [5:0]          vout;
  rldac_ladder_s       ladder;
  rldac_pin_s          pin;
  rldac_fields_s       fields;
  int                  errors;
  int                  checks;

  rldac_top u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_sleep_wake(i_sleep_wake), .i_pin_level(pin_level),
    .o_port_read_bit(port_bit), .o_ladder(ladder), .o_pin(pin), .o_fields(fields));
  rldac_ladder_model u_model (.i_ext_level(ext_level), .i_ladder(ladder), .i_pin(pin),
    .o_vout(vout), .o_pin_level(pin_level));

  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  task automatic report_and_stop();
    if (errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic wr(input logic [RLDAC_AW-1:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [RLDAC_AW-1:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    `CHK("rdata", e, o_rdata)
  endtask

  task automatic t_reset();
    #1;
    `CHK("fields", 11'h000, fields)
    `CHK("pin", 3'h0, pin)
    `CHK("ladder", 13'h1140, ladder)
    rd(RLDAC_ADDR_CONTROL, 8'h00);
    rd(RLDAC_ADDR_LEVEL, 8'h00);
  endtask

  task automatic t_masks();
    wr(RLDAC_ADDR_CONTROL, 8'hff);
    #1;
    `CHK("en", 1'b1, fields.ladder_enable)
    `CHK("on", 1'b0, ladder.ladder_on)
    tick(1);
    `CHK("on", 1'b1, ladder.ladder_on)
    rd(RLDAC_ADDR_CONTROL, 8'hed);
    wr(RLDAC_ADDR_LEVEL, 8'hff);
    rd(RLDAC_ADDR_LEVEL, 8'h1f);
    `CHK("code", 5'h1f, fields.level_code)
    wr(RLDAC_ADDR_CONTROL, 8'h6d);
    tick(1);
    `CHK("on", 1'b0, ladder.ladder_on)
  endtask

  task automatic t_sources();
    logic [1:0] p;
    for (int k = 0; k < 4; k++)
    begin
      p = k[1:0];
      wr(RLDAC_ADDR_CONTROL, {3'h1, 1'b0, p, 1'b0, p[0]});
      tick(1);
      `CHK("pss", {p == 2'h0, p == 2'h1, p == 2'h2}, {ladder.sel_supply, ladder.sel_ext_pos_ref, ladder.sel_fixed_reference})
      `CHK("nss", {p[0], ~p[0]}, {ladder.sel_ext_neg_ref, ladder.sel_ground})
      rd(RLDAC_ADDR_CONTROL, {3'h1, 1'b0, p, 1'b0, p[0]});
    end
  endtask

  task automatic t_pin();
    int n;
    ext_level <= 1'b1;
    wr(RLDAC_ADDR_LEVEL, 8'h1f);
    wr(RLDAC_ADDR_CONTROL, 8'ha0);
    tick(1);
    `CHK("pin", 3'h7, pin)
    `CHK("vout", 6'h1f, vout)
    tick(4);
    `CHK("port", 1'b0, port_bit)
    wr(RLDAC_ADDR_CONTROL, 8'h80);
    tick(1);
    `CHK("pin", 3'h0, pin)
    n = 0;
    while (port_bit !== 1'b1 && n < 8)
    begin
      tick(1);
      n++;
    end
    `CHK("port", 1'b1, port_bit)
    if (n == 8)
      report_and_stop();
    ext_level <= 1'b0;
    tick(1);
    `CHK("port", 1'b1, port_bit)
    tick(1);
    `CHK("port", 1'b0, port_bit)
  endtask

  task automatic t_clamp();
    wr(RLDAC_ADDR_CONTROL, 8'h48);
    wr(RLDAC_ADDR_LEVEL, 8'h1f);
    tick(1);
    `CHK("ends", 2'h2, {ladder.pos_end_connected, ladder.neg_end_connected})
    `CHK("vout", 6'h20, vout)
    wr(RLDAC_ADDR_CONTROL, 8'h00);
    wr(RLDAC_ADDR_LEVEL, 8'h00);
    tick(1);
    `CHK("ends", 2'h1, {ladder.pos_end_connected, ladder.neg_end_connected})
    `CHK("vout", 6'h00, vout)
    wr(RLDAC_ADDR_LEVEL, 8'h0a);
    wr(RLDAC_ADDR_CONTROL, 8'h80);
    tick(1);
    `CHK("vout", 6'h0a, vout)
  endtask

  task automatic t_sleep();
    wr(RLDAC_ADDR_CONTROL, 8'h25);
    @(posedge i_clk);
    i_sleep_wake <= 1'b1;
    @(posedge i_clk);
    i_sleep_wake <= 1'b0;
    tick(2);
    rd(RLDAC_ADDR_CONTROL, 8'h25);
    `CHK("pin", 3'h7, pin)
  endtask

  initial
  begin
    errors = 0;
    checks = 0;
    i_rst = 1'b1;
    i_addr = '0;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_sleep_wake = 1'b0;
    ext_level = 1'b0;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset();
    t_masks();
    t_sources();
    t_pin();
    t_clamp();
    t_sleep();
    // Second reset in mid-run with fields set and pin analog
    @(posedge i_clk);
    i_rst <= 1'b1;
    @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset();
    report_and_stop();
  end
endmodule
`default_nettype wire
